// ---- rtl/csms_sequencer.sv ----
// Top of the colour sensor measurement sequencer: registers,
// state machine, double-buffered results and interrupt.
// Assumes a serial front end delivers start detection, a decoded
// 5-bit address with byte write/read strobes and the clear command,
// and that the analog front end supplies four counts at conversion end.
`timescale 1ns/1ps

module csms_sequencer #(
  parameter int STEP_CYCLES = csms_pkg::STEP_CYCLES
) (
  input  wire logic        sys_clk,      // System clock 50 MHz
  input  wire logic        resetn,       // Async power-on reset, low
  input  wire logic        bus_start,    // Start condition seen, pulse
  input  wire logic [4:0]  reg_addr,     // Register address from command
  input  wire logic        reg_wr,       // Byte write strobe
  input  wire logic [7:0]  reg_wdata,    // Write data
  input  wire logic        reg_rd,       // Byte read strobe
  output logic      [7:0]  reg_rdata,    // Read data, registered
  input  wire logic        irq_clear,    // Interrupt-clear command, pulse
  input  wire logic [15:0] adc_clear,    // Clear channel count
  input  wire logic [15:0] adc_red,      // Red channel count
  input  wire logic [15:0] adc_green,    // Green channel count
  input  wire logic [15:0] adc_blue,     // Blue channel count
  output logic             adc_run,      // Front end integrating
  output logic [1:0]       analog_gain,  // Gain to front end
  output logic             irq_out       // Interrupt pin, high active
);

  ////////////////////////////////////////////////////////////////
  // Registers
  logic [7:0]  state_enables;
  logic [7:0]  integration_time_setting;
  logic [7:0]  wait_time_setting;
  logic [15:0] low_threshold;
  logic [15:0] high_threshold;
  logic [7:0]  persistence_setting;
  logic [7:0]  config_bits;
  logic [7:0]  control_bits;
  logic        irq_flag;
  logic        data_valid;
  logic [15:0] result [4];   // Clear, red, green, blue
  logic [7:0]  high_shadow;  // Upper byte frozen at low-byte read

  csms_pkg::csms_state_t state;
  csms_pkg::csms_state_t next_state;

  wire power_on_bit    = state_enables[csms_pkg::BIT_PON];
  wire measure_enable  = state_enables[csms_pkg::BIT_MEN];
  wire wait_enable     = state_enables[csms_pkg::BIT_WEN];
  wire irq_output_enable = state_enables[csms_pkg::BIT_IEN];
  wire long_wait_bit   = config_bits[csms_pkg::BIT_LONG];
  wire [3:0] persistence_count = persistence_setting[3:0];

  // Step counts: 256 minus setting, long wait twelvefold
  function automatic logic [12:0] steps_of(input logic [7:0] setting);
    steps_of = 13'(csms_pkg::STEP_COUNT_BASE) - 13'(setting);
  endfunction

  wire [12:0] wait_steps = long_wait_bit ?
                           13'(steps_of(wait_time_setting) * 13'(csms_pkg::LONG_FACTOR)) :
                           steps_of(wait_time_setting);
  wire [12:0] conv_steps = steps_of(integration_time_setting);
  wire [12:0] one_step   = 13'd1;

  ////////////////////////////////////////////////////////////////
  // State machine transitions
  logic timer_done;
  logic timer_start;
  logic [12:0] timer_steps;
  wire  conv_end = (state == csms_pkg::ST_CONV) && timer_done;

  always_comb
  begin
    next_state = state;
    case (state)
      csms_pkg::ST_SLEEP:
        if (bus_start)
          next_state = csms_pkg::ST_IDLE;
      csms_pkg::ST_IDLE:
        if (!power_on_bit)
          next_state = csms_pkg::ST_SLEEP;
        else if (measure_enable)
          next_state = csms_pkg::ST_WARMUP;
      csms_pkg::ST_WARMUP:
        if (!power_on_bit)
          next_state = csms_pkg::ST_SLEEP;
        else if (timer_done)
          next_state = wait_enable ? csms_pkg::ST_WAIT :
                                     csms_pkg::ST_INIT;
      csms_pkg::ST_WAIT:
        if (!power_on_bit || !measure_enable)
          next_state = csms_pkg::ST_IDLE;
        else if (timer_done)
          next_state = csms_pkg::ST_INIT;
      csms_pkg::ST_INIT:
        if (!power_on_bit || !measure_enable)
          next_state = csms_pkg::ST_IDLE;
        else if (timer_done)
          next_state = csms_pkg::ST_CONV;
      csms_pkg::ST_CONV:
        if (!power_on_bit || !measure_enable)
          next_state = csms_pkg::ST_IDLE;
        else if (timer_done)
          next_state = wait_enable ? csms_pkg::ST_WAIT :
                                     csms_pkg::ST_INIT;
      default:
        next_state = csms_pkg::ST_SLEEP;
    endcase
  end

  // Timer loads on entry into each timed state
  wire entering = (next_state != state) || conv_end ||
                  ((state == csms_pkg::ST_WAIT || state == csms_pkg::ST_INIT) && timer_done);
  assign timer_start = entering && (next_state == csms_pkg::ST_WARMUP ||
                                    next_state == csms_pkg::ST_WAIT ||
                                    next_state == csms_pkg::ST_INIT ||
                                    next_state == csms_pkg::ST_CONV);
  assign timer_steps = (next_state == csms_pkg::ST_WAIT) ? wait_steps :
                       (next_state == csms_pkg::ST_CONV) ? conv_steps :
                       one_step;

  csms_step_timer #(
    .STEP_CYCLES (STEP_CYCLES)
  ) u_timer (
    .sys_clk (sys_clk),
    .resetn  (resetn),
    .start   (timer_start),
    .steps   (timer_steps),
    .done    (timer_done)
  );

  // Reset lands in Sleep
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
      state <= csms_pkg::ST_SLEEP;
    else
      state <= next_state;
  end

  ////////////////////////////////////////////////////////////////
  // Persistence filter; evaluated on the same edge results land
  logic filter_hit;

  csms_threshold_filter u_filter (
    .sys_clk           (sys_clk),
    .resetn            (resetn),
    .eval              (conv_end),
    .clear_count       (adc_clear),
    .low_threshold     (low_threshold),
    .high_threshold    (high_threshold),
    .persistence_count (persistence_count),
    .hit               (filter_hit)
  );

  ////////////////////////////////////////////////////////////////
  // Host register writes
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      state_enables            <= csms_pkg::RST_ENABLE;
      integration_time_setting <= csms_pkg::RST_TIME;
      wait_time_setting        <= csms_pkg::RST_TIME;
      low_threshold            <= '0;
      high_threshold           <= '0;
      persistence_setting      <= csms_pkg::RST_ZERO;
      config_bits              <= csms_pkg::RST_ZERO;
      control_bits             <= csms_pkg::RST_ZERO;
    end
    else if (reg_wr)
    begin
      if (reg_addr == csms_pkg::OFF_ENABLE)
        state_enables <= reg_wdata;
      else if (reg_addr == csms_pkg::OFF_ITIME)
        integration_time_setting <= reg_wdata;
      else if (reg_addr == csms_pkg::OFF_WAIT_TIME_SETTING)
        wait_time_setting <= reg_wdata;
      else if (reg_addr == csms_pkg::OFF_LTHR_LO)
        low_threshold[7:0] <= reg_wdata;
      else if (reg_addr == csms_pkg::OFF_LTHR_HI)
        low_threshold[15:8] <= reg_wdata;
      else if (reg_addr == csms_pkg::OFF_HTHR_LO)
        high_threshold[7:0] <= reg_wdata;
      else if (reg_addr == csms_pkg::OFF_HTHR_HI)
        high_threshold[15:8] <= reg_wdata;
      else if (reg_addr == csms_pkg::OFF_PERSISTENCE_SETTING)
        persistence_setting <= reg_wdata;
      else if (reg_addr == csms_pkg::OFF_CONFIG)
        config_bits <= reg_wdata;
      else if (reg_addr == csms_pkg::OFF_CONTROL)
        control_bits <= reg_wdata;
    end
  end

  assign analog_gain = control_bits[1:0];

  ////////////////////////////////////////////////////////////////
  // Result capture: all four channels on one edge
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      for (int i = 0; i < 4; i++)
        result[i] <= '0;
      data_valid <= 1'b0;
    end
    else if (conv_end)
    begin
      result[0]  <= adc_clear;
      result[1]  <= adc_red;
      result[2]  <= adc_green;
      result[3]  <= adc_blue;
      data_valid <= 1'b1;
    end
  end

  // Interrupt flag: set by a filter hit, one clock after conversion end, set wins over clear
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
      irq_flag <= 1'b0;
    else if (filter_hit)
      irq_flag <= 1'b1;
    else if (irq_clear)
      irq_flag <= 1'b0;
  end

  assign irq_out = irq_flag && irq_output_enable;
  assign adc_run = (state == csms_pkg::ST_CONV);

  ////////////////////////////////////////////////////////////////
  // Read path; reading a low byte freezes its high byte
  wire        in_data  = (reg_addr >= csms_pkg::OFF_DATA0) && (reg_addr <= csms_pkg::OFF_DATA_END);
  wire [4:0]  data_off = reg_addr - csms_pkg::OFF_DATA0;
  wire [15:0] data_word = result[data_off[2:1]];
  wire [7:0]  status_byte = {3'b000, irq_flag, 3'b000, data_valid};
  logic [7:0] read_mux;

  always_comb
  begin
    read_mux = 8'h00;
    if (reg_addr == csms_pkg::OFF_ENABLE)
      read_mux = state_enables;
    else if (reg_addr == csms_pkg::OFF_ITIME)
      read_mux = integration_time_setting;
    else if (reg_addr == csms_pkg::OFF_WAIT_TIME_SETTING)
      read_mux = wait_time_setting;
    else if (reg_addr == csms_pkg::OFF_LTHR_LO)
      read_mux = low_threshold[7:0];
    else if (reg_addr == csms_pkg::OFF_LTHR_HI)
      read_mux = low_threshold[15:8];
    else if (reg_addr == csms_pkg::OFF_HTHR_LO)
      read_mux = high_threshold[7:0];
    else if (reg_addr == csms_pkg::OFF_HTHR_HI)
      read_mux = high_threshold[15:8];
    else if (reg_addr == csms_pkg::OFF_PERSISTENCE_SETTING)
      read_mux = persistence_setting;
    else if (reg_addr == csms_pkg::OFF_CONFIG)
      read_mux = config_bits;
    else if (reg_addr == csms_pkg::OFF_CONTROL)
      read_mux = control_bits;
    else if (reg_addr == csms_pkg::OFF_ID)
      read_mux = csms_pkg::ID_VALUE;
    else if (reg_addr == csms_pkg::OFF_STATUS)
      read_mux = status_byte;
    else if (in_data)
      read_mux = data_off[0] ? high_shadow : data_word[7:0];
  end

  // Shadow avoids a torn count across two byte reads
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      reg_rdata   <= 8'h00;
      high_shadow <= 8'h00;
    end
    else if (reg_rd)
    begin
      reg_rdata <= read_mux;
      if (in_data && !data_off[0])
        high_shadow <= data_word[15:8];
    end
  end

endmodule

// ---- rtl/csms_pkg.sv ----
// Constants shared by the colour sensor measurement sequencer.
// Assumes a 50 MHz system clock and a byte-wide register port.
package csms_pkg;

  // Register offsets (5-bit address space)
  localparam logic [4:0] OFF_ENABLE   = 5'h00;
  localparam logic [4:0] OFF_ITIME    = 5'h01;
  localparam logic [4:0] OFF_WAIT_TIME_SETTING    = 5'h03;
  localparam logic [4:0] OFF_LTHR_LO  = 5'h04;
  localparam logic [4:0] OFF_LTHR_HI  = 5'h05;
  localparam logic [4:0] OFF_HTHR_LO  = 5'h06;
  localparam logic [4:0] OFF_HTHR_HI  = 5'h07;
  localparam logic [4:0] OFF_PERSISTENCE_SETTING     = 5'h0C;
  localparam logic [4:0] OFF_CONFIG   = 5'h0D;
  localparam logic [4:0] OFF_CONTROL  = 5'h0F;
  localparam logic [4:0] OFF_ID       = 5'h12;
  localparam logic [4:0] OFF_STATUS   = 5'h13;
  localparam logic [4:0] OFF_DATA0    = 5'h14;
  localparam logic [4:0] OFF_DATA_END = 5'h1B;

  // Enable register fields
  localparam int BIT_PON  = 0;
  localparam int BIT_MEN  = 1;
  localparam int BIT_WEN  = 3;
  localparam int BIT_IEN  = 4;
  // Config field
  localparam int BIT_LONG = 1;
  // Status fields
  localparam int BIT_VALID = 0;
  localparam int BIT_IRQ   = 4;

  // Reset values
  localparam logic [7:0] RST_ENABLE = 8'h00;
  localparam logic [7:0] RST_TIME   = 8'hFF;
  localparam logic [7:0] RST_ZERO   = 8'h00;
  // Arbitrary neutral identity value
  localparam logic [7:0] ID_VALUE   = 8'h5A;

  // Timing: one 2.4 ms step at 50 MHz
  localparam int STEP_US     = 2400;
  localparam int CLK_MHZ     = 50;
  localparam int STEP_CYCLES = STEP_US * CLK_MHZ;
  localparam int LONG_FACTOR = 12;
  localparam int STEP_COUNT_BASE = 256;

  // Sequencer states, Gray along the main path
  typedef enum logic [2:0] {
    ST_SLEEP  = 3'b000,
    ST_IDLE   = 3'b001,
    ST_WARMUP = 3'b011,
    ST_WAIT   = 3'b010,
    ST_INIT   = 3'b110,
    ST_CONV   = 3'b111
  } csms_state_t;

endpackage

// ---- rtl/csms_step_timer.sv ----
// Step timer: counts whole steps of a programmable clock length.
// Assumes start is a one-cycle pulse and load values are stable.
`timescale 1ns/1ps
module csms_step_timer #(
  parameter int STEP_CYCLES = csms_pkg::STEP_CYCLES
) (
  input  wire logic        sys_clk,   // System clock
  input  wire logic        resetn,    // Async reset, low
  input  wire logic        start,     // Load and run
  input  wire logic [12:0] steps,     // Number of steps, 1..3072
  output logic             done       // Pulse at end
);

  logic [22:0] cyc;
  logic [12:0] left;
  logic        run;
  wire         step_end = (cyc == 23'(STEP_CYCLES - 1));

  ////////////////////////////////////////////////////////////////
  // Cycle and step counters; restart overrides a running count
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      cyc  <= '0;
      left <= '0;
      run  <= 1'b0;
      done <= 1'b0;
    end
    else
    begin
      done <= 1'b0;
      if (start)
      begin
        cyc  <= '0;
        left <= steps;
        run  <= 1'b1;
      end
      else if (run)
      begin
        cyc <= step_end ? '0 : cyc + 23'd1;
        if (step_end)
        begin
          left <= left - 13'd1;
          if (left == 13'd1)
          begin
            run  <= 1'b0;
            done <= 1'b1;
          end
        end
      end
    end
  end

endmodule

// ---- rtl/csms_threshold_filter.sv ----
// Clear-channel window test with persistence counter.
// Assumes eval pulses once per finished conversion.
`timescale 1ns/1ps
module csms_threshold_filter (
  input  wire logic        sys_clk,    // System clock
  input  wire logic        resetn,     // Async reset, low
  input  wire logic        eval,       // Conversion finished
  input  wire logic [15:0] clear_count, // New clear result
  input  wire logic [15:0] low_threshold, // Low limit
  input  wire logic [15:0] high_threshold, // High limit
  input  wire logic [3:0]  persistence_count, // Needed hits
  output logic             hit         // Pulse: raise interrupt
);

  logic [3:0] run_len;

  // Low tested first; high only when window is well formed
  wire below = clear_count < low_threshold;
  wire above = (low_threshold <= high_threshold) &&
               (clear_count > high_threshold);
  wire out_of_range = below || above;
  wire [3:0] next_len = (run_len == 4'hF) ? run_len : run_len + 4'd1;

  ////////////////////////////////////////////////////////////////
  // Consecutive out-of-range counter; zero setting fires on each out-of-range result
  always_ff @(posedge sys_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      run_len <= '0;
      hit     <= 1'b0;
    end
    else
    begin
      hit <= 1'b0;
      if (eval)
      begin
        run_len <= out_of_range ? next_len : 4'd0;
        hit     <= out_of_range && (next_len >= persistence_count);
      end
    end
  end

endmodule

// ---- verification/csms_sequencer_asserts.sv ----
// Port checker for the measurement sequencer.
// Assumes one clock domain; settings shadowed from port writes.
`timescale 1ns/1ps
module csms_sequencer_asserts #(
  parameter int STEP_CYCLES = 4
) (
  input wire logic       sys_clk,   // Clock
  input wire logic       resetn,    // Reset, low
  input wire logic       bus_start, // Start seen
  input wire logic [4:0] reg_addr,  // Address
  input wire logic       reg_wr,    // Write strobe
  input wire logic [7:0] reg_wdata, // Write data
  input wire logic       reg_rd,    // Read strobe
  input wire logic [7:0] reg_rdata, // Read data
  input wire logic       irq_clear, // Clear command
  input wire logic       adc_run,   // Converting
  input wire logic       irq_out    // Interrupt pin
);
  logic [7:0]  en_sh, it_sh, wt_sh, cf_sh;
  logic [15:0] run_cnt, gap_cnt;
  logic        woke, seen, dirty, run_q;
  int          conv_len, gap_len;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  ////////////////////////////////////////////////////////////
  // Shadow settings; any write spoils the running interval
  always_ff @(posedge sys_clk or negedge resetn)
    if (!resetn)
    begin
      {en_sh, it_sh, wt_sh, cf_sh} <= 32'h00FF_FF00;
      {run_cnt, gap_cnt, woke, seen, dirty, run_q} <= '0;
    end
    else
    begin
      if (reg_wr && reg_addr == csms_pkg::OFF_ENABLE) en_sh <= reg_wdata;
      if (reg_wr && reg_addr == csms_pkg::OFF_ITIME) it_sh <= reg_wdata;
      if (reg_wr && reg_addr == csms_pkg::OFF_WAIT_TIME_SETTING) wt_sh <= reg_wdata;
      if (reg_wr && reg_addr == csms_pkg::OFF_CONFIG) cf_sh <= reg_wdata;
      run_cnt <= adc_run ? run_cnt + 16'h0001 : 16'h0000;
      gap_cnt <= adc_run ? 16'h0000 : gap_cnt + 16'h0001;
      woke    <= woke | bus_start;
      run_q   <= adc_run;
      seen    <= reg_wr ? 1'b0 : (run_q && !adc_run) | seen;
      dirty   <= reg_wr ? 1'b1 : dirty & adc_run;
    end
  // Expected state lengths in clocks
  assign conv_len = (256 - int'(it_sh)) * STEP_CYCLES;
  assign gap_len  = STEP_CYCLES + (en_sh[3] ? (256 - int'(wt_sh)) * STEP_CYCLES
                    * (cf_sh[1] ? csms_pkg::LONG_FACTOR : 1) : 0);
  sequence s_conv_end;
    adc_run ##1 !adc_run;
  endsequence
  sequence s_conv_start;
    !adc_run ##1 adc_run;
  endsequence
  ////////////////////////////////////////////////////////////
  AST_SLEEP_UNTIL_START: assert property (!woke |-> !adc_run && !irq_out)
    else $error("measurement ran before any start");
  AST_RUN_NEEDS_ENABLES: assert property ($rose(adc_run) |-> $past(en_sh[0]) && $past(en_sh[1]))
    else $error("conversion without power and enable");
  AST_CONV_LENGTH: assert property (s_conv_end ##0 !dirty |->
    run_cnt >= conv_len && run_cnt <= conv_len + 1) else $error("conversion length wrong");
  AST_GAP_LENGTH: assert property (s_conv_start ##0 seen |->
    gap_cnt >= gap_len && gap_cnt <= gap_len + 2) else $error("wait plus init length wrong");
  AST_PIN_GATED: assert property (irq_out |-> en_sh[4])
    else $error("interrupt pin driven while disabled");
  AST_IRQ_AT_CONV_END: assert property ($rose(irq_out) && $past(en_sh[4]) |->
    $past(adc_run) || $past(adc_run, 2)) else $error("interrupt rose away from conversion end");
  AST_IRQ_HOLDS: assert property (irq_out && !irq_clear && !reg_wr |=> irq_out)
    else $error("interrupt dropped without clear");
  AST_CLEAR_DROPS: assert property (irq_clear && !adc_run && !$past(adc_run) |=> !irq_out)
    else $error("clear command ignored");
  AST_READ_ID: assert property (reg_rd && reg_addr == csms_pkg::OFF_ID |=>
    reg_rdata == csms_pkg::ID_VALUE) else $error("identity read wrong");
  AST_UNMAPPED_ZERO: assert property (reg_rd && reg_addr == 5'h02 |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
endmodule
bind csms_sequencer csms_sequencer_asserts #(.STEP_CYCLES(STEP_CYCLES)) u_chk (
  .sys_clk(sys_clk), .resetn(resetn), .bus_start(bus_start), .reg_addr(reg_addr),
  .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .irq_clear(irq_clear), .adc_run(adc_run), .irq_out(irq_out));

// ---- verification/csms_host_model.sv ----
// Host side of the register port: start, byte access, clear command.
// Assumes the sequencer answers reads one clock after the strobe.
`timescale 1ns/1ps
module csms_host_model (
  input  wire logic       sys_clk,   // System clock
  input  wire logic [7:0] reg_rdata, // Read data
  output logic            bus_start, // Start condition
  output logic [4:0]      reg_addr,  // Address
  output logic            reg_wr,    // Write strobe
  output logic [7:0]      reg_wdata, // Write data
  output logic            reg_rd,    // Read strobe
  output logic            irq_clear  // Clear command
);
  logic [7:0] rd_data;
  initial {bus_start, reg_addr, reg_wr, reg_wdata, reg_rd, irq_clear, rd_data} = '0;
  ////////////////////////////////////////////////////////////
  // Every transfer opens with a start; sc=1 is the clear command
  task automatic xfer(input logic [4:0] a, input logic w, input logic sc, input logic [7:0] d);
    @(posedge sys_clk) #1 bus_start = 1'b1;
    @(posedge sys_clk) #1 bus_start = 1'b0;
    reg_addr  = a;
    reg_wdata = d;
    reg_wr    = w & !sc;
    reg_rd    = !w & !sc;
    irq_clear = sc;
    @(posedge sys_clk) #1 rd_data = reg_rdata;
    {reg_wr, reg_rd, irq_clear} = 3'b000;
    // Released lines must not keep the last value
    reg_addr  = ~a;
    reg_wdata = ~d;
  endtask
endmodule

// ---- verification/tb.sv ----
// Self-checking bench for the measurement sequencer.
// Assumes a shortened step of four clocks.
`timescale 1ns/1ps
module tb;
  localparam int SC = 4;
  logic        sys_clk, resetn, bus_start, reg_wr, reg_rd, irq_clear, adc_run, irq_out;
  logic [4:0]  reg_addr;
  logic [7:0]  reg_wdata, reg_rdata;
  logic [1:0]  analog_gain;
  logic [15:0] adc_clear, adc_red, adc_green, adc_blue;
  int          err_total, total_checks, cyc;
  logic [15:0] th_tab [6][3];
  logic        ex_tab [6];
  csms_sequencer #(.STEP_CYCLES(SC)) dut (.sys_clk(sys_clk), .resetn(resetn), .bus_start(bus_start),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .irq_clear(irq_clear), .adc_clear(adc_clear), .adc_red(adc_red), .adc_green(adc_green),
    .adc_blue(adc_blue), .adc_run(adc_run), .analog_gain(analog_gain), .irq_out(irq_out));
  csms_host_model u_host (.sys_clk(sys_clk), .reg_rdata(reg_rdata), .bus_start(bus_start),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd), .irq_clear(irq_clear));
  ////////////////////////////////////////////////////////////
  initial
  begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  // Hang guard; the whole run needs about a thousand clocks
  always @(posedge sys_clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      err_total++;
      wrap_up();
    end
  end
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    total_checks++;
    if (g !== e)
    begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    u_host.xfer(a, 1'b1, 1'b0, d);
  endtask
  task automatic rdc(input string nm, input logic [4:0] a, input logic [7:0] m, input logic [7:0] e);
    u_host.xfer(a, 1'b0, 1'b0, 8'h00);
    chk(nm, e, u_host.rd_data & m);
  endtask
  // Returns one clock after the flag update that follows n conversion ends
  task automatic convs(input int n);
    repeat (n) @(negedge adc_run);
    repeat (2) @(posedge sys_clk);
    #1;
  endtask
  task automatic thr(input logic [15:0] lo, input logic [15:0] hi);
    wr(csms_pkg::OFF_LTHR_LO, lo[7:0]);
    wr(csms_pkg::OFF_LTHR_HI, lo[15:8]);
    wr(csms_pkg::OFF_HTHR_LO, hi[7:0]);
    wr(csms_pkg::OFF_HTHR_HI, hi[15:8]);
  endtask
  ////////////////////////////////////////////////////////////
  initial
  begin
    th_tab = '{'{16'h1000, 16'h2000, 16'h0FFF}, '{16'h1000, 16'h2000, 16'h1000},
               '{16'h1000, 16'h2000, 16'h2000}, '{16'h1000, 16'h2000, 16'h2001},
               '{16'h3000, 16'h1000, 16'h4000}, '{16'h3000, 16'h1000, 16'h2FFF}};
    ex_tab = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1};
    {resetn, err_total, total_checks, cyc} = '0;
    {adc_clear, adc_red, adc_green, adc_blue} = 64'h1234_5678_9ABC_DEF0;
    repeat (5) @(posedge sys_clk);
    #1 resetn = 1'b1;
    // Reset values, read-only and unmapped places
    rdc("enable", csms_pkg::OFF_ENABLE, 8'hFF, 8'h00);
    rdc("itime", csms_pkg::OFF_ITIME, 8'hFF, 8'hFF);
    rdc("wait_time_setting", csms_pkg::OFF_WAIT_TIME_SETTING, 8'hFF, 8'hFF);
    rdc("status", csms_pkg::OFF_STATUS, 8'hFF, 8'h00);
    wr(csms_pkg::OFF_ID, 8'h00);
    rdc("id", csms_pkg::OFF_ID, 8'hFF, csms_pkg::ID_VALUE);
    rdc("unmapped", 5'h02, 8'hFF, 8'h00);
    thr(16'h0000, 16'hFFFF);
    $display("test reset done");
    // No power: start returns to sleep
    wr(csms_pkg::OFF_ENABLE, 8'h02);
    repeat (40) @(posedge sys_clk);
    chk("run unpowered", 8'h00, {7'h00, adc_run});
    wr(csms_pkg::OFF_ENABLE, 8'h03);
    // Wake check ran before the write landed; a second start wakes it
    rdc("enable on", csms_pkg::OFF_ENABLE, 8'hFF, 8'h03);
    convs(1);
    for (int i = 0; i < 8; i++)
      rdc("data", csms_pkg::OFF_DATA0 + 5'(i), 8'hFF, 8'(64'hDEF0_9ABC_5678_1234 >> (8 * i)));
    rdc("valid", csms_pkg::OFF_STATUS, 8'h01, 8'h01);
    rdc("clear lo", csms_pkg::OFF_DATA0, 8'hFF, 8'h34);
    adc_clear = 16'hA55A;
    convs(2);
    rdc("frozen hi", 5'h15, 8'hFF, 8'h12);
    rdc("new lo", 5'h14, 8'hFF, 8'h5A);
    rdc("new hi", 5'h15, 8'hFF, 8'hA5);
    $display("test data done");
    // Window test, one hit per interrupt
    wr(csms_pkg::OFF_PERSISTENCE_SETTING, 8'h01);
    for (int i = 0; i < 6; i++)
    begin
      thr(th_tab[i][0], th_tab[i][1]);
      adc_clear = th_tab[i][2];
      convs(2);
      rdc("window", csms_pkg::OFF_STATUS, 8'h10, {3'b000, ex_tab[i], 4'h0});
      wr(csms_pkg::OFF_ENABLE, 8'h01);
      u_host.xfer(5'h00, 1'b0, 1'b1, 8'h00);
      rdc("cleared", csms_pkg::OFF_STATUS, 8'h10, 8'h00);
      wr(csms_pkg::OFF_ENABLE, 8'h03);
    end
    $display("test window done");
    // Persistence of three, pin gating, hold and clear
    thr(16'h1000, 16'h2000);
    wr(csms_pkg::OFF_PERSISTENCE_SETTING, 8'h03);
    adc_clear = 16'h1800;
    wr(csms_pkg::OFF_ENABLE, 8'h13);
    convs(2);
    u_host.xfer(5'h00, 1'b0, 1'b1, 8'h00);
    convs(1);
    adc_clear = 16'h0800;
    convs(2);
    chk("pin two hits", 8'h00, {7'h00, irq_out});
    convs(1);
    chk("pin three hits", 8'h01, {7'h00, irq_out});
    adc_clear = 16'h1800;
    convs(2);
    chk("pin held", 8'h01, {7'h00, irq_out});
    u_host.xfer(5'h00, 1'b0, 1'b1, 8'h00);
    chk("pin cleared", 8'h00, {7'h00, irq_out});
    adc_clear = 16'h0800;
    wr(csms_pkg::OFF_ENABLE, 8'h03);
    convs(4);
    chk("pin masked", 8'h00, {7'h00, irq_out});
    rdc("status irq", csms_pkg::OFF_STATUS, 8'h10, 8'h10);
    $display("test interrupt done");
    // Wait state, long wait, gain and stop
    wr(csms_pkg::OFF_ITIME, 8'hFE);
    wr(csms_pkg::OFF_WAIT_TIME_SETTING, 8'hFE);
    wr(csms_pkg::OFF_ENABLE, 8'h0B);
    convs(3);
    wr(csms_pkg::OFF_CONFIG, 8'h02);
    convs(3);
    wr(csms_pkg::OFF_CONTROL, 8'h02);
    chk("gain", 8'h02, {6'h00, analog_gain});
    wr(csms_pkg::OFF_ENABLE, 8'h00);
    repeat (20) @(posedge sys_clk);
    chk("stopped", 8'h00, {7'h00, adc_run});
    $display("test wait done");
    wrap_up();
  end
endmodule
